// File: jtag_consts.vh
`ifndef JTAG_CONSTS_VH
`define JTAG_CONSTS_VH

// Instruction register length and codes of both scan controllers.
`define IR_LEN 4
`define IR_CAPTURE 4'h1
`define IR_EXTEST 4'h0
`define IR_IDCODE 4'h1
`define IR_SAMPLE 4'h2
`define IR_USERCODE 4'h3
`define IR_ACCESS 4'h4
`define IR_BYPASS 4'hF

// Identification word field positions.
`define ID_VER_HI 31
`define ID_VER_LO 28
`define ID_PART_HI 27
`define ID_PART_LO 12
`define ID_MFR_HI 11
`define ID_MFR_LO 1
`define ID_MARK 0

// User code word field positions.
`define UC_UID_HI 31
`define UC_UID_LO 22
`define UC_REV_HI 15
`define UC_REV_LO 0

// Security word bits.
`define SEC_JTAG_OFF 0
`define SEC_OTP_OFF 13
`define SEC_HALT_OFF 14
`define SEC_UID_HI 31
`define SEC_UID_LO 22

// Access data register layout and targets.
`define ACC_LEN 35
`define ACC_TGT_HI 34
`define ACC_TGT_LO 33
`define ACC_WR 32
`define ACC_TILE 2'h0
`define ACC_SWITCH 2'h1
`define ACC_OTP 2'h2

// Reset value of the tdo flip-flop and fixed level driven on the halt line output.
`define RST_TDO 1'b0
`define RST_HALT_OUT 1'b0

`endif

// File: sync2.v
module sync2 #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input wire mclk,
	input wire nrst,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta_ff;
			reg hold_ff;
			always @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					meta_ff <= RST_VAL[i];
					hold_ff <= RST_VAL[i];
				end else begin
					meta_ff <= d[i];
					hold_ff <= meta_ff;
				end
			end
			assign q[i] = hold_ff;
		end
	endgenerate
endmodule // sync2

// File: tap_ctrl.v
module tap_ctrl (
	input wire mclk,
	input wire nrst,
	input wire step,
	input wire tms,
	input wire hold_rst,
	output wire tlr,
	output wire cap_dr,
	output wire sh_dr,
	output wire upd_dr,
	output wire cap_ir,
	output wire sh_ir,
	output wire upd_ir
);
	localparam [3:0] S_TLR = 4'h0;
	localparam [3:0] S_RTI = 4'h1;
	localparam [3:0] S_SELDR = 4'h2;
	localparam [3:0] S_CAPDR = 4'h3;
	localparam [3:0] S_SHDR = 4'h4;
	localparam [3:0] S_EX1DR = 4'h5;
	localparam [3:0] S_PDR = 4'h6;
	localparam [3:0] S_EX2DR = 4'h7;
	localparam [3:0] S_UPDR = 4'h8;
	localparam [3:0] S_SELIR = 4'h9;
	localparam [3:0] S_CAPIR = 4'hA;
	localparam [3:0] S_SHIR = 4'hB;
	localparam [3:0] S_EX1IR = 4'hC;
	localparam [3:0] S_PIR = 4'hD;
	localparam [3:0] S_EX2IR = 4'hE;
	localparam [3:0] S_UPIR = 4'hF;
	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	always @* begin
		case (state_ff)
		S_TLR: nxt_state = tms ? S_TLR : S_RTI;
		S_RTI: nxt_state = tms ? S_SELDR : S_RTI;
		S_SELDR: nxt_state = tms ? S_SELIR : S_CAPDR;
		S_CAPDR: nxt_state = tms ? S_EX1DR : S_SHDR;
		S_SHDR: nxt_state = tms ? S_EX1DR : S_SHDR;
		S_EX1DR: nxt_state = tms ? S_UPDR : S_PDR;
		S_PDR: nxt_state = tms ? S_EX2DR : S_PDR;
		S_EX2DR: nxt_state = tms ? S_UPDR : S_SHDR;
		S_UPDR: nxt_state = tms ? S_SELDR : S_RTI;
		S_SELIR: nxt_state = tms ? S_TLR : S_CAPIR;
		S_CAPIR: nxt_state = tms ? S_EX1IR : S_SHIR;
		S_SHIR: nxt_state = tms ? S_EX1IR : S_SHIR;
		S_EX1IR: nxt_state = tms ? S_UPIR : S_PIR;
		S_PIR: nxt_state = tms ? S_EX2IR : S_PIR;
		S_EX2IR: nxt_state = tms ? S_UPIR : S_SHIR;
		S_UPIR: nxt_state = tms ? S_SELDR : S_RTI;
		default: nxt_state = S_TLR;
		endcase
	end
	// Held reset wins over any clock edge, so a grounded reset pin parks here.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= S_TLR;
		end else if (hold_rst) begin
			state_ff <= S_TLR;
		end else if (step) begin
			state_ff <= nxt_state;
		end
	end
	assign tlr = (state_ff == S_TLR);
	assign cap_dr = (state_ff == S_CAPDR);
	assign sh_dr = (state_ff == S_SHDR);
	assign upd_dr = (state_ff == S_UPDR);
	assign cap_ir = (state_ff == S_CAPIR);
	assign sh_ir = (state_ff == S_SHIR);
	assign upd_ir = (state_ff == S_UPIR);
endmodule // tap_ctrl

// File: debug_access_port.v
`include "jtag_consts.vh"
module debug_access_port #(
	parameter BSR_LEN = 64,
	parameter [3:0] ID_VERSION = 4'h1, // Arbitrary value.
	parameter [15:0] ID_PART = 16'h0A51, // Arbitrary value.
	parameter [10:0] ID_MFR = 11'h2A5, // Arbitrary value.
	parameter [15:0] SILICON_REV = 16'h0001
) (
	input wire mclk,
	input wire nrst,
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire trst_n,
	output wire tdo,
	output wire tdo_oe,
	input wire halt_n_in,
	output wire halt_n_out,
	output wire halt_n_oe,
	input wire halt_out_cfg,
	input wire halt_in_cfg,
	input wire bp_hit,
	input wire resume,
	output wire debug_req,
	input wire [31:0] sec_reg,
	input wire otp_programmed,
	input wire [BSR_LEN-1:0] pin_in,
	output wire [BSR_LEN-1:0] pin_out,
	output wire pin_override,
	output wire acc_req,
	output wire acc_wr,
	output wire [1:0] acc_tgt,
	output wire [31:0] acc_wdata,
	input wire [31:0] acc_rdata,
	output wire acc_refused,
	input wire pll_lock,
	input wire [1:0] boot_mode,
	output wire [1:0] boot_sel,
	output wire boot_go
);
	localparam DW = (BSR_LEN > `ACC_LEN) ? BSR_LEN : `ACC_LEN;
	localparam SW = 6 + BSR_LEN;

	wire [SW-1:0] s_all;
	wire s_tck, s_tms, s_tdi, s_trst_n, s_halt_n, s_lock;
	wire [BSR_LEN-1:0] s_pin;
	// Pins idle as reset low, halt line high, all else low.
	sync2 #(
		.W(SW),
		.RST_VAL({{BSR_LEN{1'b0}}, 6'h20})
	) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.d({pin_in, halt_n_in, pll_lock, trst_n, tdi, tms, tck}),
		.q(s_all)
	);
	assign {s_pin, s_halt_n, s_lock, s_trst_n, s_tdi, s_tms, s_tck} = s_all;

	reg tck_q_ff;
	wire tck_rise = s_tck & ~tck_q_ff;
	wire tck_fall = ~s_tck & tck_q_ff;
	wire jtag_hold = ~s_trst_n | sec_reg[`SEC_JTAG_OFF];

	wire b_tlr, b_cdr, b_sdr, b_udr, b_cir, b_sir, b_uir;
	tap_ctrl u_tap_bs (
		.mclk(mclk),
		.nrst(nrst),
		.step(tck_rise),
		.tms(s_tms),
		.hold_rst(jtag_hold),
		.tlr(b_tlr),
		.cap_dr(b_cdr),
		.sh_dr(b_sdr),
		.upd_dr(b_udr),
		.cap_ir(b_cir),
		.sh_ir(b_sir),
		.upd_ir(b_uir)
	);
	wire c_tlr, c_cdr, c_sdr, c_udr, c_cir, c_sir, c_uir;
	tap_ctrl u_tap_chip (
		.mclk(mclk),
		.nrst(nrst),
		.step(tck_rise),
		.tms(s_tms),
		.hold_rst(jtag_hold),
		.tlr(c_tlr),
		.cap_dr(c_cdr),
		.sh_dr(c_sdr),
		.upd_dr(c_udr),
		.cap_ir(c_cir),
		.sh_ir(c_sir),
		.upd_ir(c_uir)
	);

	wire [31:0] id_word = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
	wire [9:0] uid = otp_programmed ?
		sec_reg[`SEC_UID_HI:`SEC_UID_LO] : 10'h000;
	wire [31:0] uc_word = {uid, 6'h00, SILICON_REV};

	function [DW-1:0] shr;
		input [DW-1:0] v;
		input si;
		input integer len;
		integer i;
		begin
			for (i = 0; i < DW; i = i + 1) begin
				if (i == len - 1) begin
					shr[i] = si;
				end else if (i < len - 1) begin
					shr[i] = v[i+1];
				end else begin
					shr[i] = 1'b0;
				end
			end
		end
	endfunction

	reg [`IR_LEN-1:0] b_ir_ff, b_irs_ff, c_ir_ff, c_irs_ff;
	reg [DW-1:0] b_dr_ff, c_dr_ff;
	reg [BSR_LEN-1:0] bsr_out_ff;
	reg extest_ff;
	reg acc_req_ff, acc_wr_ff, acc_refused_ff;
	reg [1:0] acc_tgt_ff;
	reg [31:0] acc_wdata_ff;
	reg tdo_ff, tdo_oe_ff;

	integer b_len, c_len;
	always @* begin
		case (b_ir_ff)
		`IR_IDCODE: b_len = 32;
		`IR_SAMPLE: b_len = BSR_LEN;
		`IR_EXTEST: b_len = BSR_LEN;
		default: b_len = 1;
		endcase
		case (c_ir_ff)
		`IR_IDCODE: c_len = 32;
		`IR_USERCODE: c_len = 32;
		`IR_ACCESS: c_len = `ACC_LEN;
		default: c_len = 1;
		endcase
	end

	// Chain order is tdi, boundary controller, chip controller, tdo.
	wire b_so = b_sir ? b_irs_ff[0] : b_dr_ff[0];
	wire c_so = c_sir ? c_irs_ff[0] : c_dr_ff[0];

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			b_ir_ff <= `IR_IDCODE;
			b_irs_ff <= {`IR_LEN{1'b0}};
			b_dr_ff <= {DW{1'b0}};
			bsr_out_ff <= {BSR_LEN{1'b0}};
			extest_ff <= 1'b0;
		end else if (jtag_hold | b_tlr) begin
			b_ir_ff <= `IR_IDCODE;
			extest_ff <= 1'b0;
		end else if (tck_rise) begin
			if (b_cir) begin
				b_irs_ff <= `IR_CAPTURE;
			end else if (b_sir) begin
				b_irs_ff <= {s_tdi, b_irs_ff[`IR_LEN-1:1]};
			end else if (b_uir) begin
				b_ir_ff <= b_irs_ff;
				extest_ff <= (b_irs_ff == `IR_EXTEST);
			end
			if (b_cdr) begin
				case (b_ir_ff)
				`IR_IDCODE: b_dr_ff <= {{(DW-32){1'b0}}, id_word};
				`IR_SAMPLE: b_dr_ff <= {{(DW-BSR_LEN){1'b0}}, s_pin};
				`IR_EXTEST: b_dr_ff <= {{(DW-BSR_LEN){1'b0}}, s_pin};
				default: b_dr_ff <= {DW{1'b0}};
				endcase
			end else if (b_sdr) begin
				b_dr_ff <= shr(b_dr_ff, s_tdi, b_len);
			end else if (b_udr && (b_ir_ff == `IR_SAMPLE ||
					b_ir_ff == `IR_EXTEST)) begin
				bsr_out_ff <= b_dr_ff[BSR_LEN-1:0];
			end
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			c_ir_ff <= `IR_IDCODE;
			c_irs_ff <= {`IR_LEN{1'b0}};
			c_dr_ff <= {DW{1'b0}};
			acc_req_ff <= 1'b0;
			acc_wr_ff <= 1'b0;
			acc_tgt_ff <= `ACC_TILE;
			acc_wdata_ff <= 32'h00000000;
			acc_refused_ff <= 1'b0;
		end else if (jtag_hold | c_tlr) begin
			c_ir_ff <= `IR_IDCODE;
			acc_req_ff <= 1'b0;
		end else begin
			acc_req_ff <= 1'b0;
			if (tck_rise) begin
				if (c_cir) begin
					c_irs_ff <= `IR_CAPTURE;
				end else if (c_sir) begin
					c_irs_ff <= {b_so, c_irs_ff[`IR_LEN-1:1]};
				end else if (c_uir) begin
					c_ir_ff <= c_irs_ff;
				end
				if (c_cdr) begin
					case (c_ir_ff)
					`IR_IDCODE: c_dr_ff <= {{(DW-32){1'b0}}, id_word};
					`IR_USERCODE: c_dr_ff <= {{(DW-32){1'b0}}, uc_word};
					`IR_ACCESS: c_dr_ff <= {{(DW-34){1'b0}},
						acc_refused_ff, 1'b0, acc_rdata};
					default: c_dr_ff <= {DW{1'b0}};
					endcase
				end else if (c_sdr) begin
					c_dr_ff <= shr(c_dr_ff, b_so, c_len);
				end else if (c_udr && c_ir_ff == `IR_ACCESS) begin
					// OTP reach is dropped when security forbids it.
					if (c_dr_ff[`ACC_TGT_HI:`ACC_TGT_LO] == `ACC_OTP &&
							sec_reg[`SEC_OTP_OFF]) begin
						acc_refused_ff <= 1'b1;
					end else begin
						acc_refused_ff <= 1'b0;
						acc_req_ff <= 1'b1;
						acc_wr_ff <= c_dr_ff[`ACC_WR];
						acc_tgt_ff <= c_dr_ff[`ACC_TGT_HI:`ACC_TGT_LO];
						acc_wdata_ff <= c_dr_ff[31:0];
					end
				end
			end
		end
	end

	// Data leaves on the falling test clock edge so the far end samples it on
	// the next rising edge with half a period of margin.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tck_q_ff <= 1'b0;
			tdo_ff <= `RST_TDO;
			tdo_oe_ff <= 1'b0;
		end else begin
			tck_q_ff <= s_tck;
			if (jtag_hold) begin
				tdo_ff <= `RST_TDO;
				tdo_oe_ff <= 1'b0;
			end else if (tck_fall) begin
				tdo_ff <= c_so;
				tdo_oe_ff <= c_sdr | c_sir;
			end
		end
	end

	// Halt line handling.
	reg halt_drive_ff, halt_seen_ff, debug_req_ff;
	wire halt_off = sec_reg[`SEC_HALT_OFF];
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			halt_drive_ff <= 1'b0;
			halt_seen_ff <= 1'b1;
			debug_req_ff <= 1'b0;
		end else begin
			halt_seen_ff <= s_halt_n;
			if (halt_off | ~halt_out_cfg | (resume & ~bp_hit)) begin
				halt_drive_ff <= 1'b0;
			end else if (bp_hit) begin
				halt_drive_ff <= 1'b1;
			end
			debug_req_ff <= halt_in_cfg & ~halt_off & ~halt_drive_ff &
				halt_seen_ff & ~s_halt_n;
		end
	end

	// boot after lock
	// The boot mode strap is caught on the first clock after release.
	reg started_ff, boot_go_ff;
	reg [1:0] boot_sel_ff;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			started_ff <= 1'b0;
			boot_sel_ff <= 2'h0;
			boot_go_ff <= 1'b0;
		end else begin
			started_ff <= 1'b1;
			if (!started_ff) begin
				boot_sel_ff <= boot_mode;
			end
			if (started_ff && s_lock) begin
				boot_go_ff <= 1'b1;
			end
		end
	end

	assign tdo = tdo_ff;
	assign tdo_oe = tdo_oe_ff;
	assign halt_n_out = `RST_HALT_OUT;
	assign halt_n_oe = halt_drive_ff;
	assign debug_req = debug_req_ff;
	assign pin_out = bsr_out_ff;
	assign pin_override = extest_ff;
	assign acc_req = acc_req_ff;
	assign acc_wr = acc_wr_ff;
	assign acc_tgt = acc_tgt_ff;
	assign acc_wdata = acc_wdata_ff;
	assign acc_refused = acc_refused_ff;
	assign boot_sel = boot_sel_ff;
	assign boot_go = boot_go_ff;
endmodule // debug_access_port

// File: dap_properties.sv
module dap_properties (
	input wire mclk,
	input wire nrst,
	input wire trst_n,
	input wire tdo_oe,
	input wire halt_n_in,
	input wire halt_n_out,
	input wire halt_n_oe,
	input wire halt_out_cfg,
	input wire halt_in_cfg,
	input wire bp_hit,
	input wire resume,
	input wire debug_req,
	input wire [31:0] sec_reg,
	input wire acc_req,
	input wire pll_lock,
	input wire boot_go
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Input mode counts only while the device itself is not pulling.
	sequence s_halt_drop;
		(halt_in_cfg && !sec_reg[14] && !halt_n_oe && halt_n_in) [*3]
		##1 (halt_in_cfg && !sec_reg[14] && !halt_n_oe && !halt_n_in);
	endsequence
	sequence s_lock_held;
		pll_lock [*8];
	endsequence
	a_trst_quiet: assert property (!trst_n [*6] |-> !tdo_oe && !acc_req)
		else $error("scan port active under test reset");
	a_sec_shut: assert property (sec_reg[0] [*4] |-> !tdo_oe && !acc_req)
		else $error("scan port active while disabled");
	a_halt_drive: assert property (
		bp_hit && halt_out_cfg && !sec_reg[14] |=> halt_n_oe)
		else $error("halt line not pulled after breakpoint");
	a_halt_cause: assert property (
		$rose(halt_n_oe) |-> $past(bp_hit && halt_out_cfg))
		else $error("halt line pulled without breakpoint");
	a_halt_low: assert property (halt_n_oe |-> !halt_n_out)
		else $error("halt line driven high");
	a_halt_locked: assert property (sec_reg[14] |=> !halt_n_oe)
		else $error("halt line pulled while locked");
	a_debug_entry: assert property (s_halt_drop |-> ##[1:5] debug_req)
		else $error("no debug entry after halt line fell");
	a_boot_after_lock: assert property (
		$rose(boot_go) |-> $past(pll_lock, 2))
		else $error("boot started before lock");
	a_boot_follows: assert property (s_lock_held |-> boot_go)
		else $error("boot not started after lock");
	a_acc_pulse: assert property (acc_req |=> !acc_req)
		else $error("access request longer than one cycle");
	a_reset_clean: assert property (
		$rose(nrst) |-> !boot_go && !debug_req && !halt_n_oe)
		else $error("outputs not cleared by reset");
endmodule // dap_properties

bind debug_access_port dap_properties u_props (.mclk(mclk), .nrst(nrst),
	.trst_n(trst_n), .tdo_oe(tdo_oe), .halt_n_in(halt_n_in),
	.halt_n_out(halt_n_out), .halt_n_oe(halt_n_oe),
	.halt_out_cfg(halt_out_cfg), .halt_in_cfg(halt_in_cfg), .bp_hit(bp_hit),
	.resume(resume), .debug_req(debug_req), .sec_reg(sec_reg),
	.acc_req(acc_req), .pll_lock(pll_lock), .boot_go(boot_go));

// File: jtag_master.sv
module jtag_master (
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	input wire tdo
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b0;
	end
	task automatic set_trst(input logic lvl);
		trst_n = lvl;
		#200;
	endtask
	// The clock stands low between frames; tdo is read late in the high half.
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#40 tck = 1'b1;
		#35 q = tdo;
		#5 tck = 1'b0;
	endtask
	task automatic scan(input logic ir, input logic [63:0] v, input int n,
		output logic [63:0] o);
		logic q;
		o = 64'h0;
		step(1'b0, 1'b0, q);
		step(1'b1, 1'b0, q);
		if (ir) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[i], q);
			o[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
endmodule // jtag_master

// File: test_access_debug_port_tb_top.sv
module test_access_debug_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Identity values are arbitrary.
	localparam logic [3:0] VER = 4'h3;
	localparam logic [15:0] PART = 16'h5C2E;
	localparam logic [10:0] MFR = 11'h1B7;
	localparam logic [15:0] REV = 16'h00A4;
	logic mclk = 1'b0, nrst = 1'b0, bp_hit = 1'b0, resume = 1'b0;
	logic halt_out_cfg = 1'b0, halt_in_cfg = 1'b0, ext_low = 1'b0;
	logic otp_prog = 1'b0, pll_lock = 1'b0, oe_seen = 1'b0;
	logic [31:0] sec_reg = 32'h0, acc_rdata = 32'h0;
	logic [7:0] pin_in = 8'h0;
	logic [1:0] boot_mode = 2'h2;
	wire tck, tms, tdi, trst_n, tdo, tdo_oe, halt_n_out, halt_n_oe;
	wire debug_req, pin_override, acc_req, acc_wr, acc_refused, boot_go;
	wire [7:0] pin_out;
	wire [1:0] acc_tgt, boot_sel;
	wire [31:0] acc_wdata;
	// Open-drain line with a pull-up.
	wire halt_line = !(halt_n_oe && !halt_n_out) && !ext_low;
	int n_mismatch = 0, n_checks = 0, n_dbg = 0, n_acc = 0;

	debug_access_port #(.BSR_LEN(8), .ID_VERSION(VER), .ID_PART(PART),
		.ID_MFR(MFR), .SILICON_REV(REV)) dut (.mclk(mclk), .nrst(nrst),
		.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
		.tdo_oe(tdo_oe), .halt_n_in(halt_line), .halt_n_out(halt_n_out),
		.halt_n_oe(halt_n_oe), .halt_out_cfg(halt_out_cfg),
		.halt_in_cfg(halt_in_cfg), .bp_hit(bp_hit), .resume(resume),
		.debug_req(debug_req), .sec_reg(sec_reg), .otp_programmed(otp_prog),
		.pin_in(pin_in), .pin_out(pin_out), .pin_override(pin_override),
		.acc_req(acc_req), .acc_wr(acc_wr), .acc_tgt(acc_tgt),
		.acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
		.acc_refused(acc_refused), .pll_lock(pll_lock),
		.boot_mode(boot_mode), .boot_sel(boot_sel), .boot_go(boot_go));
	jtag_master jm (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
		.tdo(tdo));

	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		if (debug_req === 1'b1) n_dbg++;
		if (acc_req === 1'b1) n_acc++;
		if (tdo_oe === 1'b1) oe_seen = 1'b1;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	function automatic logic [31:0] id_word();
		return {VER, PART, MFR, 1'b1};
	endfunction
	function automatic logic [31:0] uc_word(input logic [31:0] s,
		input logic p);
		return {p ? s[31:22] : 10'h000, 6'h00, REV};
	endfunction

	initial begin
		#300000;
		n_mismatch++;
		tally_and_finish;
	end

	initial begin
		logic [63:0] o;
		logic [63:0] v;
		logic [34:0] acc_exp;
		void'($urandom(32'hE309F0A1));
		cyc(8);
		nrst = 1'b1;
		cyc(10);
		chk(boot_go, 1'b0);
		pll_lock = 1'b1;
		cyc(8);
		chk({boot_go, boot_sel}, {1'b1, boot_mode});
		done("boot");
		jm.set_trst(1'b0);
		jm.set_trst(1'b1);
		jm.scan(1'b0, 64'h0, 64, o);
		chk(o, {id_word(), id_word()});
		chk(oe_seen, 1'b1);
		done("idcode");
		for (int k = 0; k < 2; k++) begin
			cyc(1);
			sec_reg = $urandom & 32'hFFFFFFFE;
			otp_prog = k[0];
			jm.scan(1'b1, 64'hF3, 8, o);
			chk(o[7:0], 8'h11);
			jm.scan(1'b0, 64'h0, 33, o);
			chk(o[32:0], {1'b0, uc_word(sec_reg, otp_prog)});
		end
		done("usercode");
		cyc(1);
		pin_in = 8'($urandom);
		jm.scan(1'b1, 64'h2F, 8, o);
		jm.scan(1'b0, 64'h0, 9, o);
		chk(o[8:0], {pin_in, 1'b0});
		v = 64'($urandom);
		jm.scan(1'b1, 64'h0F, 8, o);
		jm.scan(1'b0, v, 9, o);
		chk({pin_override, pin_out}, {1'b1, v[8:1]});
		done("boundary");
		n_acc = 0;
		for (int t = 0; t < 4; t++) begin
			cyc(1);
			sec_reg = (t == 3) ? 32'h00002000 : 32'h0;
			acc_rdata = $urandom;
			v = {$urandom, $urandom};
			v[34:33] = (t == 3) ? 2'h2 : t[1:0];
			if (t < 3) acc_exp = v[34:0];
			jm.scan(1'b1, 64'hF4, 8, o);
			jm.scan(1'b0, v, 36, o);
			chk(o[34:0], {2'h0, acc_rdata});
			chk({acc_refused, acc_tgt, acc_wr, acc_wdata},
				{t == 3, acc_exp});
			if (t < 3) chk(n_acc, t + 1);
		end
		done("access");
		for (int s = 0; s < 2; s++) begin
			cyc(1);
			sec_reg = 32'(s == 0);
			if (s == 1) jm.set_trst(1'b0);
			oe_seen = 1'b0;
			n_acc = 0;
			jm.scan(1'b1, 64'hF4, 8, o);
			jm.scan(1'b0, 64'h0, 36, o);
			chk({oe_seen, n_acc[3:0]}, 5'h00);
		end
		jm.set_trst(1'b1);
		done("disable");
		cyc(1);
		sec_reg = 32'h0;
		halt_out_cfg = 1'b1;
		bp_hit = 1'b1;
		cyc(1);
		bp_hit = 1'b0;
		cyc(2);
		chk({halt_n_oe, halt_line}, 2'h2);
		resume = 1'b1;
		cyc(1);
		resume = 1'b0;
		cyc(2);
		chk({halt_n_oe, halt_line}, 2'h1);
		sec_reg[14] = 1'b1;
		bp_hit = 1'b1;
		cyc(1);
		bp_hit = 1'b0;
		cyc(2);
		chk(halt_n_oe, 1'b0);
		halt_out_cfg = 1'b0;
		halt_in_cfg = 1'b1;
		n_dbg = 0;
		for (int h = 0; h < 2; h++) begin
			sec_reg[14] = h[0];
			cyc(5);
			ext_low = 1'b1;
			cyc(10);
			ext_low = 1'b0;
		end
		cyc(5);
		chk(n_dbg, 1);
		done("halt");
		nrst = 1'b0;
		#1 chk(boot_go, 1'b0);
		cyc(3);
		nrst = 1'b1;
		cyc(10);
		chk(boot_go, 1'b1);
		done("reset");
		tally_and_finish;
	end
endmodule // test_access_debug_port_tb_top
